/* design/hcs_consts.vh */
// constants for the harmonic count sequencer: frequencies, times, codes, map
// assumes a 25 MHz clk; included by every design file of the block
`ifndef HCS_CONSTS_VH
`define HCS_CONSTS_VH
`define HCS_CLK_HZ      32'h17D7840
`define HCS_MS_PER_S    32'h3E8
`define HCS_US_PER_S    32'hF4240
`define HCS_HZ_PER_KHZ  32'h3E8
`define HCS_START_KHZ   19'h55730
`define HCS_STOP_KHZ    19'h493E0
`define HCS_STEP_KHZ    19'h00064
`define HCS_OFFSET_KHZ  19'h001F4
`define HCS_REF_KHZ     19'h00032
`define HCS_SWEEP_MS    32'h96
`define HCS_SYNC_LAT    32'h2
`define HCS_NORM_US     32'h57FD0
`define HCS_NARR_US     32'h57F8
`define HCS_WIDE_MS     32'h830
`define HCS_GATE_LONG_S 32'h4
`define HCS_GATE_ONE_S  32'h1
`define HCS_GATE_FAST_US 32'hA
`define HCS_DECADE      32'hA
`define HCS_QHZ_PER_HZ  32'h4
`define HCS_BEAT_PRESCALE 32'h10
`define HCS_NARR_BITS   4'h7
`define HCS_NORM_BITS   4'hA
`define HCS_WIDE_BITS   4'hD
`define HCS_TOL_NORMAL  2'h0
`define HCS_TOL_NARROW  2'h1
`define HCS_TOL_WIDE    2'h2
`define HCS_RES_1HZ     3'h0
`define HCS_RES_1MHZ    3'h6
`define HCS_CTRL_START  0
`define HCS_CTRL_HALT   1
`define HCS_CTRL_RES_LO 2
`define HCS_CTRL_RES_HI 4
`define HCS_REG_CTRL    4'h0
`define HCS_REG_STATUS  4'h1
`define HCS_REG_MAIN    4'h2
`define HCS_REG_HARM    4'h3
`define HCS_REG_CNTA    4'h4
`define HCS_REG_CNTB    4'h5
`define HCS_REG_GATE    4'h6
`define HCS_REG_UNK_LO  4'h7
`define HCS_REG_UNK_HI  4'h8
`endif

/* design/hcs_prs_gen.v */
// switching sequence source: shift register with the all-zero state spliced in
// assumes the caller steps it once per chip and clears it before each search
`timescale 1ns/100ps
`include "hcs_consts.vh"
module hcs_prs_gen #(
    parameter W = `HCS_WIDE_BITS
) (
    input  wire       clk,
    input  wire       rstn,
    input  wire       clear,
    input  wire       step,
    input  wire [1:0] tolSel,
    output wire       chip
);
    reg  [W-1:0] sr_r;
    wire [W-1:0] mask;
    wire [W-1:0] top;
    wire         lowZero;
    wire         fb;

    function [W-1:0] lenMask;
        input [1:0] t;
        begin
            case (t)
                `HCS_TOL_NARROW: lenMask = {W{1'b1}} >> (W - `HCS_NARR_BITS);
                `HCS_TOL_WIDE:   lenMask = {W{1'b1}} >> (W - `HCS_WIDE_BITS);
                default:         lenMask = {W{1'b1}} >> (W - `HCS_NORM_BITS);
            endcase
        end
    endfunction

    function tapFb;
        input [W-1:0] s;
        input [1:0]   t;
        begin
            case (t)
                `HCS_TOL_NARROW: tapFb = s[6] ^ s[5];
                `HCS_TOL_WIDE:   tapFb = s[12] ^ s[3] ^ s[2] ^ s[0];
                default:         tapFb = s[9] ^ s[6];
            endcase
        end
    endfunction

    assign mask    = lenMask(tolSel);
    assign top     = mask ^ (mask >> 1);
    // splicing in the zero state gives 2^n chips, half of them high
    assign lowZero = ~|(sr_r & (mask >> 1));
    assign fb      = tapFb(sr_r, tolSel) ^ lowZero;
    assign chip    = |(sr_r & top);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr_r <= {{(W-1){1'b0}}, 1'b1};
        end else if (clear) begin
            sr_r <= {{(W-1){1'b0}}, 1'b1};
        end else if (step) begin
            sr_r <= {sr_r[W-2:0], fb} & mask;
        end
    end
endmodule

/* design/hcs_sequencer.v */
// harmonic count sequencer: sweep, harmonic search, final gate, result
// assumes async pins from the detector/front end; beat pulses prescaled outside
`timescale 1ns/100ps
`include "hcs_consts.vh"
module hcs_sequencer #(
    parameter SWEEP_CYC = `HCS_SWEEP_MS * (`HCS_CLK_HZ / `HCS_MS_PER_S),
    parameter NORM_CYC  = `HCS_NORM_US * (`HCS_CLK_HZ / `HCS_US_PER_S),
    parameter NARR_CYC  = `HCS_NARR_US * (`HCS_CLK_HZ / `HCS_US_PER_S),
    parameter WIDE_CYC  = `HCS_WIDE_MS * (`HCS_CLK_HZ / `HCS_MS_PER_S),
    parameter GATE4_CYC = `HCS_GATE_LONG_S * `HCS_CLK_HZ
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire [3:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdata,
    input  wire        beatInBandPin,
    input  wire        beatWidePin,
    input  wire        beatPulsePin,
    input  wire        tolWidePin,
    input  wire        tolNarrowPin,
    output reg  [12:0] mainDivider,
    output reg  [12:0] offsetDivider,
    output wire        selOffsetOsc,
    output wire        cntAEn,
    output wire        cntBEn,
    output wire        busy
);
    localparam S_IDLE = 3'h0;
    localparam S_SWEEP = 3'h1;
    localparam S_NDET = 3'h2;
    localparam S_DIV = 3'h3;
    localparam S_GATE = 3'h4;
    localparam S_CALC = 3'h5;
    localparam S_DONE = 3'h6;
    localparam S_FAIL = 3'h7;

    localparam [31:0] STEPS = (`HCS_START_KHZ - `HCS_STOP_KHZ) / `HCS_STEP_KHZ + 1;
    localparam [31:0] STEP_CYC = SWEEP_CYC / STEPS;
    localparam [31:0] DIV_STEP = `HCS_STEP_KHZ / `HCS_REF_KHZ;
    localparam [18:0] DIV_START_W = `HCS_START_KHZ / `HCS_REF_KHZ;
    localparam [18:0] DIV_OFFSET_W = `HCS_OFFSET_KHZ / `HCS_REF_KHZ;
    localparam [12:0] DIV_START = DIV_START_W[12:0];
    localparam [12:0] DIV_OFFSET = DIV_OFFSET_W[12:0];
    localparam [31:0] NORM_CHIP = NORM_CYC >> `HCS_NORM_BITS;
    localparam [31:0] NARR_CHIP = NARR_CYC >> `HCS_NARR_BITS;
    localparam [31:0] WIDE_CHIP = WIDE_CYC >> `HCS_WIDE_BITS;
    localparam [63:0] OFF_HZ = `HCS_OFFSET_KHZ * `HCS_HZ_PER_KHZ;
    localparam [63:0] CNT_DEN = 64'h2 * `HCS_CLK_HZ * `HCS_BEAT_PRESCALE;
    localparam [63:0] DNORM = OFF_HZ * (NORM_CHIP << `HCS_NORM_BITS) / CNT_DEN;
    localparam [63:0] DNARR = OFF_HZ * (NARR_CHIP << `HCS_NARR_BITS) / CNT_DEN;
    localparam [63:0] DWIDE = OFF_HZ * (WIDE_CHIP << `HCS_WIDE_BITS) / CNT_DEN;
    localparam [31:0] FAST_CYC = `HCS_GATE_FAST_US * (`HCS_CLK_HZ / `HCS_US_PER_S);
    localparam [31:0] D1 = `HCS_DECADE;
    localparam [31:0] D2 = D1 * `HCS_DECADE;
    localparam [31:0] D3 = D2 * `HCS_DECADE;
    localparam [31:0] D4 = D3 * `HCS_DECADE;
    localparam [31:0] D5 = D4 * `HCS_DECADE;
    localparam [39:0] QMAIN = `HCS_QHZ_PER_HZ * `HCS_HZ_PER_KHZ;

    // pin synchronisers: beat band, wide, pulse, wide tol, narrow tol
    wire [4:0] pinIn;
    reg  [4:0] meta_r;
    reg  [4:0] sync_r;
    reg        pulseDly_r;
    wire       inBand;
    wire       wideOk;
    wire       beatEdge;

    reg  [2:0]  state_r;
    reg  [18:0] mainKhz_r;
    reg  [31:0] tmr_r;
    reg  [13:0] chipCnt_r;
    reg  [31:0] cntA_r;
    reg  [31:0] cntB_r;
    reg  [31:0] gateCnt_r;
    reg  [31:0] harm_r;
    reg  [31:0] divRem_r;
    reg  [31:0] divQ_r;
    reg  [5:0]  divCnt_r;
    reg  [39:0] unk_r;
    reg  [2:0]  res_r;
    reg  [1:0]  tol_r;
    reg         signPlus_r;
    reg         beatLost_r;
    reg         sweepFail_r;

    wire        chip;
    wire        chipEnd;
    wire        prsClear;
    wire        startReq;
    wire        haltReq;
    wire [31:0] chipCyc;
    wire [13:0] chipLast;
    wire [31:0] deltaCnt;
    wire [31:0] diff;
    wire [32:0] remSh;
    wire [32:0] trial;
    wire [39:0] beatQ;
    wire [39:0] nMainQ;
    wire        lossEvt;

    assign pinIn = {tolNarrowPin, tolWidePin, beatPulsePin, beatWidePin, beatInBandPin};

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gSync
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= pinIn[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulseDly_r <= 1'b0;
        end else begin
            pulseDly_r <= sync_r[2];
        end
    end

    assign inBand   = sync_r[0];
    assign wideOk   = sync_r[1];
    assign beatEdge = sync_r[2] & ~pulseDly_r;

    function [31:0] gateCyc;
        input [2:0] r;
        begin
            case (r)
                `HCS_RES_1HZ: gateCyc = `HCS_GATE_ONE_S * `HCS_CLK_HZ;
                3'h1: gateCyc = GATE4_CYC / D1;
                3'h2: gateCyc = GATE4_CYC / D2;
                3'h3: gateCyc = GATE4_CYC / D3;
                3'h4: gateCyc = GATE4_CYC / D4;
                3'h5: gateCyc = GATE4_CYC / D5;
                default: gateCyc = FAST_CYC;
            endcase
        end
    endfunction

    // quarter-hertz per prescaled count, per resolution
    function [39:0] qMult;
        input [2:0] r;
        begin
            case (r)
                `HCS_RES_1HZ: qMult = `HCS_QHZ_PER_HZ * `HCS_BEAT_PRESCALE;
                3'h1: qMult = D1 * `HCS_BEAT_PRESCALE;
                3'h2: qMult = D2 * `HCS_BEAT_PRESCALE;
                3'h3: qMult = D3 * `HCS_BEAT_PRESCALE;
                3'h4: qMult = D4 * `HCS_BEAT_PRESCALE;
                3'h5: qMult = D5 * `HCS_BEAT_PRESCALE;
                default: qMult = `HCS_QHZ_PER_HZ * `HCS_US_PER_S / `HCS_GATE_FAST_US * `HCS_BEAT_PRESCALE;
            endcase
        end
    endfunction

    assign chipCyc = (tol_r == `HCS_TOL_WIDE) ? WIDE_CHIP :
                     (tol_r == `HCS_TOL_NARROW) ? NARR_CHIP : NORM_CHIP;
    assign chipLast = (tol_r == `HCS_TOL_WIDE) ? ~(14'h3FFF << `HCS_WIDE_BITS) :
                      (tol_r == `HCS_TOL_NARROW) ? ~(14'h3FFF << `HCS_NARR_BITS) :
                      ~(14'h3FFF << `HCS_NORM_BITS);
    assign deltaCnt = (tol_r == `HCS_TOL_WIDE) ? DWIDE[31:0] :
                      (tol_r == `HCS_TOL_NARROW) ? DNARR[31:0] : DNORM[31:0];
    assign chipEnd  = (state_r == S_NDET) && (tmr_r == chipCyc - 32'h1);

    hcs_prs_gen #(
        .W      (`HCS_WIDE_BITS)
    ) uPrs (
        .clk    (clk),
        .rstn   (rstn),
        .clear  (prsClear),
        .step   (chipEnd),
        .tolSel (tol_r),
        .chip   (chip)
    );

    // prs is held at seed outside the search so every run starts alike
    assign prsClear = (state_r != S_NDET);
    assign selOffsetOsc = (state_r == S_NDET) & chip;
    assign cntBEn = (state_r == S_NDET) & chip;
    assign cntAEn = ((state_r == S_NDET) & ~chip) | (state_r == S_GATE);
    assign busy = (state_r != S_IDLE) && (state_r != S_DONE) && (state_r != S_FAIL);

    assign startReq = regWr && (regAddr == `HCS_REG_CTRL) && regWdata[`HCS_CTRL_START];
    assign haltReq  = regWr && (regAddr == `HCS_REG_CTRL) && regWdata[`HCS_CTRL_HALT];

    assign diff  = (cntB_r > cntA_r) ? (cntB_r - cntA_r) : (cntA_r - cntB_r);
    assign remSh = {divRem_r, divQ_r[31]};
    assign trial = remSh - {1'b0, deltaCnt};
    assign beatQ = gateCnt_r * qMult(res_r);
    assign nMainQ = harm_r[7:0] * mainKhz_r * QMAIN;
    assign lossEvt = ((state_r == S_NDET) || (state_r == S_DIV) || (state_r == S_GATE)) && !wideOk;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r     <= S_IDLE;
            mainKhz_r   <= `HCS_START_KHZ;
            mainDivider <= DIV_START;
            offsetDivider <= DIV_START - DIV_OFFSET;
            tmr_r       <= 32'h0;
            chipCnt_r   <= 14'h0;
            cntA_r      <= 32'h0;
            cntB_r      <= 32'h0;
            gateCnt_r   <= 32'h0;
            harm_r      <= 32'h0;
            divRem_r    <= 32'h0;
            divQ_r      <= 32'h0;
            divCnt_r    <= 6'h0;
            unk_r       <= 40'h0;
            res_r       <= `HCS_RES_1HZ;
            tol_r       <= `HCS_TOL_NORMAL;
            signPlus_r  <= 1'b0;
            beatLost_r  <= 1'b0;
            sweepFail_r <= 1'b0;
        end else if (startReq) begin
            // start, even mid-run, goes back to the top of the sweep
            state_r     <= S_SWEEP;
            mainKhz_r   <= `HCS_START_KHZ;
            mainDivider <= DIV_START;
            offsetDivider <= DIV_START - DIV_OFFSET;
            tmr_r       <= 32'h0;
            res_r       <= regWdata[`HCS_CTRL_RES_HI:`HCS_CTRL_RES_LO];
            tol_r       <= sync_r[3] ? `HCS_TOL_WIDE :
                           sync_r[4] ? `HCS_TOL_NARROW : `HCS_TOL_NORMAL;
            // loss in the same cycle as a restart still sets: set wins
            beatLost_r  <= lossEvt;
            sweepFail_r <= 1'b0;
        end else if (haltReq) begin
            state_r <= S_IDLE;
        end else begin
            // wide flag loss while counting taints the harmonic result
            if (lossEvt) begin
                beatLost_r <= 1'b1;
            end
            case (state_r)
                S_SWEEP: begin
                    // flag lags a synth step by the sync chain; a stale high would stop too early
                    if (inBand && (tmr_r >= `HCS_SYNC_LAT)) begin
                        state_r   <= S_NDET;
                        tmr_r     <= 32'h0;
                        chipCnt_r <= 14'h0;
                        cntA_r    <= 32'h0;
                        cntB_r    <= 32'h0;
                    end else if (tmr_r == STEP_CYC - 32'h1) begin
                        tmr_r <= 32'h0;
                        if (mainKhz_r == `HCS_STOP_KHZ) begin
                            state_r     <= S_FAIL;
                            sweepFail_r <= 1'b1;
                        end else begin
                            mainKhz_r   <= mainKhz_r - `HCS_STEP_KHZ;
                            mainDivider <= mainDivider - DIV_STEP[12:0];
                            offsetDivider <= mainDivider - DIV_STEP[12:0] - DIV_OFFSET;
                        end
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                S_NDET: begin
                    if (beatEdge && !chip) begin
                        cntA_r <= cntA_r + 32'h1;
                    end
                    if (beatEdge && chip) begin
                        cntB_r <= cntB_r + 32'h1;
                    end
                    if (chipEnd) begin
                        tmr_r     <= 32'h0;
                        chipCnt_r <= chipCnt_r + 14'h1;
                        // full 2^n chips: equal on-time per counter
                        if (chipCnt_r == chipLast) begin
                            state_r  <= S_DIV;
                            divQ_r   <= diff + (deltaCnt >> 1);
                            divRem_r <= 32'h0;
                            divCnt_r <= 6'h0;
                        end
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                S_DIV: begin
                    // restoring divide, one quotient bit per clock
                    if (!trial[32]) begin
                        divRem_r <= trial[31:0];
                        divQ_r   <= {divQ_r[30:0], 1'b1};
                    end else begin
                        divRem_r <= remSh[31:0];
                        divQ_r   <= {divQ_r[30:0], 1'b0};
                    end
                    divCnt_r <= divCnt_r + 6'h1;
                    if (divCnt_r == 6'h1F) begin
                        harm_r     <= {divQ_r[30:0], ~trial[32]};
                        signPlus_r <= (cntA_r < cntB_r);
                        state_r    <= S_GATE;
                        tmr_r      <= 32'h0;
                        gateCnt_r  <= 32'h0;
                    end
                end
                S_GATE: begin
                    if (beatEdge) begin
                        gateCnt_r <= gateCnt_r + 32'h1;
                    end
                    if (tmr_r == gateCyc(res_r) - 32'h1) begin
                        state_r <= S_CALC;
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                S_CALC: begin
                    // result in quarter hertz so every gate length divides evenly
                    unk_r   <= signPlus_r ? (nMainQ + beatQ) : (nMainQ - beatQ);
                    state_r <= S_DONE;
                end
                S_IDLE: begin
                    state_r <= S_IDLE;
                end
                S_DONE: begin
                    state_r <= S_DONE;
                end
                S_FAIL: begin
                    state_r <= S_FAIL;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 32'h0;
        end else if (regRd) begin
            case (regAddr)
                `HCS_REG_CTRL:   regRdata <= {27'h0, res_r, 2'h0};
                `HCS_REG_STATUS: regRdata <= {23'h0, tol_r, signPlus_r, beatLost_r, sweepFail_r,
                                              busy, state_r};
                `HCS_REG_MAIN:   regRdata <= {13'h0, mainKhz_r};
                `HCS_REG_HARM:   regRdata <= harm_r;
                `HCS_REG_CNTA:   regRdata <= cntA_r;
                `HCS_REG_CNTB:   regRdata <= cntB_r;
                `HCS_REG_GATE:   regRdata <= gateCnt_r;
                `HCS_REG_UNK_LO: regRdata <= unk_r[31:0];
                `HCS_REG_UNK_HI: regRdata <= {24'h0, unk_r[39:32]};
                default:         regRdata <= 32'h0;
            endcase
        end else begin
            regRdata <= 32'h0;
        end
    end
endmodule

/* tb/hcs_front_model.sv */
// front end model: in-band and wide beat flags, prescaled beat pulse train
// assumes the bench picks the stop divider and the beat rate per oscillator
`timescale 1ns/100ps
module hcs_front_model (
    input  logic        clk,
    input  logic [12:0] mainDivider,
    input  logic        selOffsetOsc,
    input  logic [12:0] stopDiv,
    input  logic        dropWide,
    input  logic [7:0]  perA,
    input  logic [7:0]  perB,
    output logic        beatInBandPin,
    output logic        beatWidePin,
    output logic        beatPulsePin
);
    logic [7:0] phase = 8'h0;
    logic       pulse_r = 1'b0;
    assign beatPulsePin = pulse_r;
    // beat lands in band once the sweep reaches the stop setting
    assign beatInBandPin = mainDivider <= stopDiv;
    assign beatWidePin = beatInBandPin && !dropWide;
    // beat rate follows the selected oscillator, so the two counts differ
    always @(posedge clk) begin
        if (phase >= (selOffsetOsc ? perB : perA)) begin
            phase <= 8'h0;
            pulse_r <= !pulse_r;
        end else
            phase <= phase + 8'h1;
    end
endmodule

/* tb/hcs_seq_properties.sv */
// checker for the sequencer: dividers, mux, counter enables, read bus
// assumes divider reset 7000 and a 32-cycle idle gap before the gate
`timescale 1ns/100ps
module hcs_seq_checker (
    input logic        clk,
    input logic        rstn,
    input logic        regRd,
    input logic [31:0] regRdata,
    input logic [12:0] mainDivider,
    input logic [12:0] offsetDivider,
    input logic        selOffsetOsc,
    input logic        cntAEn,
    input logic        cntBEn,
    input logic        busy
);
    logic signed [17:0] bal;
    logic [7:0]         idleRun;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // enable balance; the gate drives it negative, cleared when idle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bal <= 18'sh0;
            idleRun <= 8'h0;
        end else begin
            if (!busy)
                bal <= 18'sh0;
            else if (cntBEn)
                bal <= bal + 18'sh1;
            else if (cntAEn)
                bal <= bal - 18'sh1;
            if (busy && !cntAEn && !cntBEn)
                idleRun <= (idleRun == 8'hFF) ? idleRun : idleRun + 8'h1;
            else
                idleRun <= 8'h0;
        end
    end
    AST_OFFSET_DIV: assert property (offsetDivider == mainDivider - 13'h00A)
        else $error("offset divider not 500 kHz below main");
    AST_SWEEP_STEP: assert property ($changed(mainDivider) |->
        mainDivider == $past(mainDivider) - 13'h002 || mainDivider == 13'h1B58)
        else $error("main divider moved other than one step");
    AST_SWEEP_FLOOR: assert property (mainDivider >= 13'h1770)
        else $error("main divider below 300 MHz");
    AST_CNTB_SEL: assert property (cntBEn == selOffsetOsc)
        else $error("counter B enable differs from mux select");
    AST_ONE_COUNTER: assert property (!(cntAEn && cntBEn))
        else $error("both counters enabled");
    AST_IDLE_QUIET: assert property (!busy |-> !selOffsetOsc && !cntAEn)
        else $error("mux or counter active while idle");
    AST_SEARCH_HOLD: assert property (selOffsetOsc |-> $stable(mainDivider))
        else $error("synth moved during search");
    AST_EQUAL_TIME: assert property ($rose(cntAEn) && idleRun > 8'h1E |-> bal == 18'sh0)
        else $error("counter enable times unequal");
    AST_GATE_RUN: assert property ($rose(cntAEn) && idleRun > 8'h1E |=> cntAEn [*3])
        else $error("final gate not held on counter A");
    AST_READ_ZERO: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its cycle");
endmodule
bind hcs_sequencer hcs_seq_checker chk (.clk(clk), .rstn(rstn), .regRd(regRd), .regRdata(regRdata),
    .mainDivider(mainDivider), .offsetDivider(offsetDivider), .selOffsetOsc(selOffsetOsc),
    .cntAEn(cntAEn), .cntBEn(cntBEn), .busy(busy));

/* tb/hcs_sequencer_tb.sv */
// bench for the sequencer: register tasks, three tolerance runs, sweep failure
// assumes shortened counts: step 10, chip 10 (5 wide), gate base 4000 cycles
`timescale 1ns/100ps
`include "hcs_consts.vh"
module hcs_sequencer_tb;
    logic        clk, rstn, regWr, regRd, dropWide, tolW, tolN;
    logic        selOffsetOsc, cntAEn, cntBEn, busy, inBand, wide, pulse;
    logic [3:0]  regAddr;
    logic [31:0] regWdata, regRdata, st;
    logic [12:0] mainDivider, offsetDivider, stopDiv;
    logic [7:0]  perA, perB;
    logic [31:0] cA, cB, hN, gC, uLo, uHi;
    longint      uExp;
    // 500 kHz counts over half the search, prescaled by 16; narrow rounds to none
    int          deltaTab[3] = '{6, 0, 25};
    // quarter hertz per prescaled count at res 3 and res 1
    int          qmTab[3] = '{16000, 0, 160};
    int          nErrors, checkCount, enCnt, bCnt, k;
    // search cycles per tolerance; res 3 gives 4, 1 MHz 250, res 1 400
    int          searchTab[3] = '{10240, 1280, 40960};
    int          gateTab[3] = '{4, 250, 400};
    logic [2:0]  resTab[3] = '{3'h3, 3'h6, 3'h1};
    hcs_sequencer #(.SWEEP_CYC(5010), .NORM_CYC(10240), .NARR_CYC(1280), .WIDE_CYC(40960),
        .GATE4_CYC(4000)) dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .beatInBandPin(inBand),
        .beatWidePin(wide), .beatPulsePin(pulse), .tolWidePin(tolW), .tolNarrowPin(tolN),
        .mainDivider(mainDivider), .offsetDivider(offsetDivider), .selOffsetOsc(selOffsetOsc),
        .cntAEn(cntAEn), .cntBEn(cntBEn), .busy(busy));
    hcs_front_model fe (.clk(clk), .mainDivider(mainDivider), .selOffsetOsc(selOffsetOsc),
        .stopDiv(stopDiv), .dropWide(dropWide), .perA(perA), .perB(perB),
        .beatInBandPin(inBand), .beatWidePin(wide), .beatPulsePin(pulse));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (cntAEn || cntBEn)
            enCnt++;
        if (cntBEn)
            bCnt++;
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task waitState(input logic [2:0] s, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            rd(`HCS_REG_STATUS, st);
            if (st[2:0] === s)
                break;
        end
        chk("state", {29'h0, st[2:0]}, {29'h0, s});
    endtask
    task endOfTest;
        $display("checks %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        {regWr, regRd, dropWide, tolW, tolN} = 5'h00;
        regAddr = 4'h0;
        regWdata = 32'h0;
        stopDiv = 13'h1AF4;
        {perA, perB} = 16'h0201;
        repeat (12) @(posedge clk);
        #1 chk("mainDivider", {19'h0, mainDivider}, 32'h1B58);
        chk("offsetDivider", {19'h0, offsetDivider}, 32'h1B4E);
        rstn <= 1'b1;
        rd(4'hF, st);
        chk("unmapped", st, 32'h0);
        // resolution is taken only with a start; halt then parks it
        wr(`HCS_REG_CTRL, 32'h9);
        wr(`HCS_REG_CTRL, 32'h2);
        waitState(3'h0, 4);
        rd(`HCS_REG_CTRL, st);
        chk("resolution", {29'h0, st[4:2]}, 32'h2);
        $display("test registers done");
        for (k = 0; k < 3; k++) begin
            tolW <= (k == 2);
            tolN <= (k >= 1); // wide pin must win over narrow
            perA <= (k == 1) ? 8'h1 : 8'h2;
            perB <= (k == 1) ? 8'h2 : 8'h1;
            repeat (3) @(posedge clk);
            enCnt = 0;
            bCnt = 0;
            wr(`HCS_REG_CTRL, {27'h0, resTab[k], 2'h1});
            waitState(3'h2, 1000);
            chk("stopDivider", {19'h0, mainDivider}, 32'h1AF4);
            chk("stopOffset", {19'h0, offsetDivider}, 32'h1AEA);
            rd(`HCS_REG_MAIN, st);
            chk("mainKhz", st, 32'h543A8);
            if (k == 1)
                dropWide <= 1'b1;
            waitState(3'h6, 45000);
            chk("tol", {30'h0, st[8:7]}, k);
            chk("signPlus", {31'h0, st[6]}, {31'h0, k != 1});
            chk("wideLost", {31'h0, st[5]}, {31'h0, k == 1});
            chk("busy", {31'h0, st[3]}, 32'h0);
            chk("enableCycles", enCnt, searchTab[k] + gateTab[k]);
            chk("offsetCycles", bCnt, searchTab[k] / 2);
            if (k != 1) begin
                rd(`HCS_REG_CNTA, cA);
                rd(`HCS_REG_CNTB, cB);
                rd(`HCS_REG_HARM, hN);
                rd(`HCS_REG_GATE, gC);
                rd(`HCS_REG_UNK_LO, uLo);
                rd(`HCS_REG_UNK_HI, uHi);
                chk("harmonic", hN, ((cB - cA) + deltaTab[k] / 2) / deltaTab[k]);
                // 345000 kHz in quarter hertz, plus sign since B counted more
                uExp = hN[7:0] * 64'h52412100 + gC * qmTab[k];
                chk("unknownLo", uLo, uExp[31:0]);
                chk("unknownHi", uHi, uExp[63:32]);
            end
            dropWide <= 1'b0;
            $display("test tolerance run %0d done", k);
        end
        stopDiv <= 13'h0;
        {tolW, tolN} <= 2'h0;
        wr(`HCS_REG_CTRL, 32'hD);
        waitState(3'h7, 4000);
        chk("sweepFail", {31'h0, st[4]}, 32'h1);
        wr(`HCS_REG_CTRL, 32'h2);
        waitState(3'h0, 10);
        $display("test sweep failure done");
        endOfTest;
    end
    // whole run is about 60000 cycles, the wide search most of it
    initial begin
        #(40 * 80000);
        nErrors++;
        endOfTest;
    end
endmodule
